// File: pkg/wdtta_pkg.sv
package wdtta_pkg;

	// register addresses on the special function register port
	localparam logic [7:0] WDTTA_ADDR_CLKCTL = 8'h8e;
	localparam logic [7:0] WDTTA_ADDR_TAKEY  = 8'hc7;
	localparam logic [7:0] WDTTA_ADDR_WDCTL  = 8'hd8;
	localparam logic [7:0] WDTTA_ADDR_EIE    = 8'he8;

	// unlock key bytes
	localparam logic [7:0] WDTTA_KEY_FIRST  = 8'haa;
	localparam logic [7:0] WDTTA_KEY_SECOND = 8'h55;

	// field positions
	localparam int WDTTA_SEL_HI_BIT    = 7;
	localparam int WDTTA_SEL_LO_BIT    = 6;
	localparam int WDTTA_PORF_BIT      = 6;
	localparam int WDTTA_WARN_FLAG_BIT = 3;
	localparam int WDTTA_TRF_BIT       = 2;
	localparam int WDTTA_RFE_BIT       = 1;
	localparam int WDTTA_RESTART_BIT   = 0;
	localparam int WDTTA_IRQ_EN_BIT    = 4;

	// reset values
	localparam logic [7:0] WDTTA_CLKCTL_RST = 8'h00;
	localparam logic [7:0] WDTTA_EIE_RST    = 8'h00;
	localparam logic [7:0] WDTTA_RDATA_RST  = 8'h00;

	// unlock window: three machine cycles of four clocks
	localparam int         WDTTA_CLK_PER_MC   = 4;
	localparam int         WDTTA_WINDOW_MC    = 3;
	localparam logic [3:0] WDTTA_WINDOW_CLKS  = 4'(WDTTA_CLK_PER_MC * WDTTA_WINDOW_MC);
	localparam logic [3:0] WDTTA_WINDOW_ZERO  = 4'h0;

	// timeout counter
	localparam int          WDTTA_CNT_W     = 27;
	localparam logic [26:0] WDTTA_WARN_GAP  = 27'h000200;
	localparam logic [26:0] WDTTA_CNT_ZERO  = 27'h0000000;
	localparam logic [26:0] WDTTA_CNT_ONE   = 27'h0000001;
	localparam logic [26:0] WDTTA_TIMEOUT_0 = 27'h0020000;
	localparam logic [26:0] WDTTA_TIMEOUT_1 = 27'h0100000;
	localparam logic [26:0] WDTTA_TIMEOUT_2 = 27'h0800000;
	localparam logic [26:0] WDTTA_TIMEOUT_3 = 27'h4000000;

	typedef enum logic [1:0] {
		WDTTA_KEY_IDLE,
		WDTTA_KEY_ARMED,
		WDTTA_KEY_OPEN
	} wdtta_key_e;

endpackage

// File: verilog/wdtta_unlock.sv
`timescale 1ns/1ps
module wdtta_unlock
	import wdtta_pkg::*;
(
	input  wire logic       core_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [7:0] sfr_addr_i,
	input  wire logic       sfr_wr_i,
	input  wire logic [7:0] sfr_wdata_i,
	output logic            open_o
);

	wdtta_key_e state_q;
	wdtta_key_e state_d;
	logic [3:0] win_q;
	logic [3:0] win_d;
	logic       open_q;
	logic       open_d;
	logic       key_wr;

	assign key_wr = sfr_wr_i && (sfr_addr_i == WDTTA_ADDR_TAKEY);
	assign open_o = open_q;

	// key sequencer; any write between the two keys other than a repeated first key disarms
	always_comb
	begin
		state_d = state_q;
		win_d   = win_q;
		if (state_q == WDTTA_KEY_OPEN)
		begin
			win_d = win_q - 4'h1;
		end
		case (state_q)
			WDTTA_KEY_IDLE,
			WDTTA_KEY_OPEN:
			begin
				if (key_wr && sfr_wdata_i == WDTTA_KEY_FIRST)
					state_d = WDTTA_KEY_ARMED;
				else if (state_q == WDTTA_KEY_OPEN && win_q == 4'h1)
					state_d = WDTTA_KEY_IDLE;
			end
			WDTTA_KEY_ARMED:
			begin
				if (key_wr && sfr_wdata_i == WDTTA_KEY_SECOND)
				begin
					state_d = WDTTA_KEY_OPEN;
					win_d   = WDTTA_WINDOW_CLKS;
				end
				else if (key_wr && sfr_wdata_i == WDTTA_KEY_FIRST)
					state_d = WDTTA_KEY_ARMED;
				else if (sfr_wr_i)
					state_d = WDTTA_KEY_IDLE;
			end
			default:
				state_d = WDTTA_KEY_IDLE;
		endcase
		if (state_d != WDTTA_KEY_OPEN)
			win_d = WDTTA_WINDOW_ZERO;
		open_d = (state_d == WDTTA_KEY_OPEN);
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			state_q <= WDTTA_KEY_IDLE;
			win_q   <= WDTTA_WINDOW_ZERO;
			open_q  <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			win_q   <= win_d;
			open_q  <= open_d;
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence seq_second_key;
		state_q == WDTTA_KEY_ARMED && key_wr && sfr_wdata_i == WDTTA_KEY_SECOND;
	endsequence

	// a first key byte inside the window re-arms, so it ends the count early
	sequence seq_window_step;
		state_q == WDTTA_KEY_OPEN && win_q != 4'h1 &&
		!(key_wr && sfr_wdata_i == WDTTA_KEY_FIRST);
	endsequence

	chk_window_length: assert property (seq_second_key |=>
		open_o && win_q == WDTTA_WINDOW_CLKS)
		else $error("unlock window did not open at full length");
	chk_window_count: assert property (seq_window_step |=>
		open_o && win_q == $past(win_q) - 4'h1)
		else $error("unlock window closed early");
	chk_window_close: assert property (state_q == WDTTA_KEY_OPEN && win_q == 4'h1 |=>
		!open_o)
		else $error("unlock window open too long");
	chk_window_idle: assert property (state_q == WDTTA_KEY_IDLE |-> !open_o)
		else $error("window open without key sequence");

endmodule

// File: verilog/wdtta_top.sv
`timescale 1ns/1ps
module wdtta_top
	import wdtta_pkg::*;
#(
	parameter logic [26:0] TIMEOUT_0 = WDTTA_TIMEOUT_0,
	parameter logic [26:0] TIMEOUT_1 = WDTTA_TIMEOUT_1,
	parameter logic [26:0] TIMEOUT_2 = WDTTA_TIMEOUT_2,
	parameter logic [26:0] TIMEOUT_3 = WDTTA_TIMEOUT_3
)
(
	input  wire logic       core_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       por_n_i,
	input  wire logic       nv_reset_disable_i,
	input  wire logic [7:0] sfr_addr_i,
	input  wire logic       sfr_wr_i,
	input  wire logic [7:0] sfr_wdata_i,
	input  wire logic       sfr_rd_i,
	output logic      [7:0] sfr_rdata_o,
	output logic            warn_irq_o,
	output logic            wake_o,
	output logic            cpu_reset_o
);

	logic [7:0]  clock_control_q;
	logic [7:0]  clock_control_d;
	logic [7:0]  ext_irq_enable_q;
	logic [7:0]  ext_irq_enable_d;
	logic        warn_irq_flag_q;
	logic        warn_irq_flag_d;
	logic        timeout_reset_flag_q;
	logic        timeout_reset_flag_d;
	logic        reset_function_enable_q;
	logic        reset_function_enable_d;
	logic        por_flag_q;
	logic        por_flag_d;
	logic [26:0] cnt_q;
	logic [26:0] cnt_d;
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;
	logic        irq_q;
	logic        irq_d;
	logic        cpu_reset_q;
	logic        cpu_reset_d;
	logic [26:0] warn_point;
	logic [26:0] reset_point;
	logic        unlock_open;
	logic        wr_wdctl;
	logic        prot_wr;
	logic        restart_acc;
	logic        at_warn;
	logic        at_reset;
	logic        wr_clkctl;
	logic        tail_run_q;
	logic        tail_run_d;
	logic [26:0] tail_cnt_q;
	logic [26:0] tail_cnt_d;

	// key sequencer for the protected bits
	wdtta_unlock u_unlock (
		.core_clk_i  (core_clk_i),
		.rst_n_i     (rst_n_i && por_n_i),
		.sfr_addr_i  (sfr_addr_i),
		.sfr_wr_i    (sfr_wr_i),
		.sfr_wdata_i (sfr_wdata_i),
		.open_o      (unlock_open)
	);

	// timeout selection from clock control bits 7:6
	always_comb
	begin
		case ({clock_control_q[WDTTA_SEL_HI_BIT], clock_control_q[WDTTA_SEL_LO_BIT]})
			2'h0:    warn_point = TIMEOUT_0 - WDTTA_CNT_ONE;
			2'h1:    warn_point = TIMEOUT_1 - WDTTA_CNT_ONE;
			2'h2:    warn_point = TIMEOUT_2 - WDTTA_CNT_ONE;
			2'h3:    warn_point = TIMEOUT_3 - WDTTA_CNT_ONE;
			default: warn_point = TIMEOUT_0 - WDTTA_CNT_ONE;
		endcase
	end

	// reset point trails the warning by a fixed tail, independent of irq enable
	assign reset_point = warn_point + WDTTA_WARN_GAP;

	// decode of register writes
	assign wr_wdctl    = sfr_wr_i && (sfr_addr_i == WDTTA_ADDR_WDCTL);
	assign wr_clkctl   = sfr_wr_i && (sfr_addr_i == WDTTA_ADDR_CLKCTL);
	assign prot_wr     = wr_wdctl && unlock_open;
	assign restart_acc = prot_wr && sfr_wdata_i[WDTTA_RESTART_BIT];
	assign at_warn     = (cnt_q == warn_point);
	// >= so that a shortened select mid-count cannot run away past the end
	assign at_reset    = (cnt_q >= reset_point);

	// register file and timeout next-state; hardware sets beat software clears
	always_comb
	begin
		clock_control_d         = clock_control_q;
		ext_irq_enable_d        = ext_irq_enable_q;
		warn_irq_flag_d         = warn_irq_flag_q;
		timeout_reset_flag_d    = timeout_reset_flag_q;
		reset_function_enable_d = reset_function_enable_q;
		por_flag_d              = por_flag_q;
		cnt_d                   = cnt_q + WDTTA_CNT_ONE;
		cpu_reset_d             = 1'b0;
		rdata_d                 = rdata_q;

		if (sfr_wr_i && sfr_addr_i == WDTTA_ADDR_CLKCTL)
			clock_control_d = sfr_wdata_i;
		if (sfr_wr_i && sfr_addr_i == WDTTA_ADDR_EIE)
			ext_irq_enable_d = sfr_wdata_i;
		// timeout flag is the one status bit cleared without the unlock
		if (wr_wdctl && !sfr_wdata_i[WDTTA_TRF_BIT])
			timeout_reset_flag_d = 1'b0;
		if (prot_wr)
		begin
			por_flag_d              = sfr_wdata_i[WDTTA_PORF_BIT];
			warn_irq_flag_d         = sfr_wdata_i[WDTTA_WARN_FLAG_BIT];
			reset_function_enable_d = sfr_wdata_i[WDTTA_RFE_BIT];
		end

		// restart zeroes only the counter; the same protected write loads the flags from its data
		if (restart_acc || at_reset)
			cnt_d = WDTTA_CNT_ZERO;
		if (at_warn)
			warn_irq_flag_d = 1'b1;
		if (at_reset)
		begin
			timeout_reset_flag_d = 1'b1;
			cpu_reset_d          = reset_function_enable_q;
		end

		// read data is registered; unmapped addresses read as zero
		if (sfr_rd_i)
		begin
			case (sfr_addr_i)
				WDTTA_ADDR_CLKCTL: rdata_d = clock_control_q;
				WDTTA_ADDR_EIE:    rdata_d = ext_irq_enable_q;
				WDTTA_ADDR_WDCTL:
				begin
					rdata_d                      = WDTTA_RDATA_RST;
					rdata_d[WDTTA_PORF_BIT]      = por_flag_q;
					rdata_d[WDTTA_WARN_FLAG_BIT] = warn_irq_flag_q;
					rdata_d[WDTTA_TRF_BIT]       = timeout_reset_flag_q;
					rdata_d[WDTTA_RFE_BIT]       = reset_function_enable_q;
				end
				default:           rdata_d = WDTTA_RDATA_RST;
			endcase
		end

		// interrupt request also serves as the wake request
		irq_d = warn_irq_flag_d && ext_irq_enable_d[WDTTA_IRQ_EN_BIT];
	end

	// power-on sets the por flag, loads the reset enable from the option bit and clears the rest; cpu reset keeps the source flags readable
	always_ff @(posedge core_clk_i)
	begin
		if (!por_n_i)
		begin
			clock_control_q         <= WDTTA_CLKCTL_RST;
			ext_irq_enable_q        <= WDTTA_EIE_RST;
			warn_irq_flag_q         <= 1'b0;
			timeout_reset_flag_q    <= 1'b0;
			reset_function_enable_q <= !nv_reset_disable_i;
			por_flag_q              <= 1'b1;
			cnt_q                   <= WDTTA_CNT_ZERO;
			rdata_q                 <= WDTTA_RDATA_RST;
			irq_q                   <= 1'b0;
			cpu_reset_q             <= 1'b0;
		end
		else if (!rst_n_i)
		begin
			clock_control_q         <= WDTTA_CLKCTL_RST;
			ext_irq_enable_q        <= WDTTA_EIE_RST;
			warn_irq_flag_q         <= 1'b0;
			timeout_reset_flag_q    <= timeout_reset_flag_q;
			reset_function_enable_q <= !nv_reset_disable_i;
			por_flag_q              <= por_flag_q;
			cnt_q                   <= WDTTA_CNT_ZERO;
			rdata_q                 <= WDTTA_RDATA_RST;
			irq_q                   <= 1'b0;
			cpu_reset_q             <= 1'b0;
		end
		else
		begin
			clock_control_q         <= clock_control_d;
			ext_irq_enable_q        <= ext_irq_enable_d;
			warn_irq_flag_q         <= warn_irq_flag_d;
			timeout_reset_flag_q    <= timeout_reset_flag_d;
			reset_function_enable_q <= reset_function_enable_d;
			por_flag_q              <= por_flag_d;
			cnt_q                   <= cnt_d;
			rdata_q                 <= rdata_d;
			irq_q                   <= irq_d;
			cpu_reset_q             <= cpu_reset_d;
		end
	end

	assign sfr_rdata_o = rdata_q;
	assign warn_irq_o  = irq_q;
	assign wake_o      = irq_q;
	assign cpu_reset_o = cpu_reset_q;

	// checking aid: clocks since the warning, kept apart from the compare points
	// so that a wrong tail length cannot hide behind the same arithmetic
	always_comb
	begin
		tail_run_d = tail_run_q;
		tail_cnt_d = tail_cnt_q + WDTTA_CNT_ONE;
		if (restart_acc || at_reset || wr_clkctl)
			tail_run_d = 1'b0;
		else if (at_warn)
		begin
			tail_run_d = 1'b1;
			tail_cnt_d = WDTTA_CNT_ZERO;
		end
	end

	// the aid restarts with either reset
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i || !por_n_i)
		begin
			tail_run_q <= 1'b0;
			tail_cnt_q <= WDTTA_CNT_ZERO;
		end
		else
		begin
			tail_run_q <= tail_run_d;
			tail_cnt_q <= tail_cnt_d;
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i || !por_n_i);

	sequence seq_counting;
		!restart_acc && !at_reset;
	endsequence

	sequence seq_full_timeout;
		at_reset && !restart_acc;
	endsequence

	chk_counter_advance: assert property (seq_counting |=>
		cnt_q == $past(cnt_q) + WDTTA_CNT_ONE)
		else $error("counter did not advance by one");
	chk_warn_set: assert property (at_warn |=> warn_irq_flag_q)
		else $error("warning flag not set at selected count");
	chk_tail_length: assert property (at_reset |-> cnt_q - warn_point == WDTTA_WARN_GAP)
		else $error("timeout tail is not 512 clocks");
	chk_timeout_flag: assert property (seq_full_timeout |=>
		timeout_reset_flag_q && cnt_q == WDTTA_CNT_ZERO)
		else $error("timeout flag or counter wrong after timeout");
	chk_reset_out: assert property (cpu_reset_o |->
		timeout_reset_flag_q && $past(reset_function_enable_q))
		else $error("cpu reset without enabled timeout");
	chk_restart_clear: assert property (restart_acc |=> cnt_q == WDTTA_CNT_ZERO)
		else $error("restart did not clear counter");
	chk_irq_gate: assert property (warn_irq_flag_q && ext_irq_enable_q[WDTTA_IRQ_EN_BIT] |->
		warn_irq_o)
		else $error("enabled warning not driving interrupt");
	chk_wake_follow: assert property (wake_o == warn_irq_o)
		else $error("wake request differs from interrupt");
	chk_locked_enable: assert property (wr_wdctl && !unlock_open |=>
		reset_function_enable_q == $past(reset_function_enable_q))
		else $error("protected bit changed without unlock");
	chk_flag_hold: assert property (timeout_reset_flag_q &&
		!(wr_wdctl && !sfr_wdata_i[WDTTA_TRF_BIT]) |=> timeout_reset_flag_q)
		else $error("timeout flag dropped without clear");

	// tail measured by the independent aid, not by the compare points
	chk_tail_count: assert property (at_reset && tail_run_q |->
		tail_cnt_q == WDTTA_WARN_GAP - WDTTA_CNT_ONE)
		else $error("warning to timeout is not 512 clocks");
	chk_reset_enabled: assert property (at_reset && reset_function_enable_q |=>
		cpu_reset_o)
		else $error("enabled timeout gave no cpu reset");
	chk_reset_pulse: assert property (cpu_reset_o |=>
		!cpu_reset_o)
		else $error("cpu reset longer than one clock");
	chk_irq_masked: assert property (!ext_irq_enable_q[WDTTA_IRQ_EN_BIT] |->
		!warn_irq_o)
		else $error("masked warning drives interrupt");
	chk_locked_flags: assert property (wr_wdctl && !unlock_open && !at_warn |=>
		warn_irq_flag_q == $past(warn_irq_flag_q) && por_flag_q == $past(por_flag_q))
		else $error("protected flag changed without unlock");
	chk_warn_source: assert property (!warn_irq_flag_q && !at_warn && !prot_wr |=>
		!warn_irq_flag_q)
		else $error("warning flag set without count");
	chk_read_flags: assert property (sfr_rd_i && sfr_addr_i == WDTTA_ADDR_WDCTL |=>
		sfr_rdata_o[WDTTA_WARN_FLAG_BIT] == $past(warn_irq_flag_q) &&
		sfr_rdata_o[WDTTA_TRF_BIT] == $past(timeout_reset_flag_q))
		else $error("status read does not show the flags");
	chk_restart_flags: assert property (restart_acc && warn_irq_flag_q &&
		sfr_wdata_i[WDTTA_WARN_FLAG_BIT] |=> warn_irq_flag_q)
		else $error("restart cleared the warning flag");
	chk_flag_clear: assert property (wr_wdctl && !sfr_wdata_i[WDTTA_TRF_BIT] &&
		!at_reset |=> !timeout_reset_flag_q)
		else $error("timeout flag not cleared by write");

endmodule

// File: tb/wdtta_top_test.sv
`timescale 1ns/1ps
module wdtta_top_test;
	import wdtta_pkg::*;
	// shortened interrupt counts; the 512-clock tail is unchanged
	localparam logic [26:0] TSEL [4] = '{27'h40, 27'h80, 27'h100, 27'h200};
	logic       core_clk_i;
	logic       rst_n_i;
	logic       por_n_i;
	logic       nv_reset_disable_i;
	logic [7:0] sfr_addr_i;
	logic       sfr_wr_i;
	logic [7:0] sfr_wdata_i;
	logic       sfr_rd_i;
	logic [7:0] sfr_rdata_o;
	logic       warn_irq_o;
	logic       wake_o;
	logic       cpu_reset_o;
	int         bad_count = 0;
	int         compares = 0;
	int         resets = 0;

	wdtta_top #(
		.TIMEOUT_0(TSEL[0]),
		.TIMEOUT_1(TSEL[1]),
		.TIMEOUT_2(TSEL[2]),
		.TIMEOUT_3(TSEL[3])
	) uut (
		.core_clk_i        (core_clk_i),
		.rst_n_i           (rst_n_i),
		.por_n_i           (por_n_i),
		.nv_reset_disable_i(nv_reset_disable_i),
		.sfr_addr_i        (sfr_addr_i),
		.sfr_wr_i          (sfr_wr_i),
		.sfr_wdata_i       (sfr_wdata_i),
		.sfr_rd_i          (sfr_rd_i),
		.sfr_rdata_o       (sfr_rdata_o),
		.warn_irq_o        (warn_irq_o),
		.wake_o            (wake_o),
		.cpu_reset_o       (cpu_reset_o)
	);

	// 10 MHz crystal clock
	initial
	begin
		core_clk_i = 1'b0;
		forever #50 core_clk_i = ~core_clk_i;
	end

	// count reset pulses so missing or stretched pulses show up
	always @(posedge core_clk_i)
		if (cpu_reset_o === 1'b1)
			resets <= resets + 1;

	function automatic logic [7:0] exp_wd(bit por, bit warn, bit trf, bit rfe);
		return {1'b0, por, 2'b00, warn, trf, rfe, 1'b0};
	endfunction

	task automatic stop_test;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// one bus cycle; every signal driven once, 1 ns after the edge
	task automatic cyc(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d);
		sfr_wr_i = wr;
		sfr_rd_i = rd;
		sfr_addr_i = a;
		sfr_wdata_i = d;
		@(posedge core_clk_i);
		#1;
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
		cyc(1'b0, 1'b1, a, 8'h00);
		check(what, 32'(exp), 32'(sfr_rdata_o));
	endtask

	task automatic idle(input int n);
		repeat (n) cyc(1'b0, 1'b0, 8'h00, 8'h00);
	endtask

	task automatic unlock_wr(input int gap, input logic [7:0] d);
		cyc(1'b1, 1'b0, WDTTA_ADDR_TAKEY, WDTTA_KEY_FIRST);
		cyc(1'b1, 1'b0, WDTTA_ADDR_TAKEY, WDTTA_KEY_SECOND);
		idle(gap);
		cyc(1'b1, 1'b0, WDTTA_ADDR_WDCTL, d);
	endtask

	// bounded wait: pick 0 for the warning output, 1 for the reset pulse
	task automatic wait_out(input bit pick, output int n);
		n = 0;
		while ((pick ? cpu_reset_o : warn_irq_o) !== 1'b1)
		begin
			idle(1);
			n++;
			if (n > 3000)
			begin
				bad_count++;
				$display("wrong value wait expected 1 seen 0");
				stop_test();
			end
		end
	endtask

	// main sequence
	initial
	begin
		int         seed;
		int         nw;
		int         n2;
		int         total;
		int         base;
		int         r0;
		logic [7:0] a;
		logic [7:0] v;
		bit         en;
		bit         rfe;
		seed = $urandom(61342);
		rst_n_i = 1'b0;
		por_n_i = 1'b0;
		nv_reset_disable_i = 1'b0;
		sfr_addr_i = 8'h00;
		sfr_wr_i = 1'b0;
		sfr_wdata_i = 8'h00;
		sfr_rd_i = 1'b0;
		base = 0;
		repeat (20) @(posedge core_clk_i);
		#1;
		rst_n_i = 1'b1;
		por_n_i = 1'b1;
		rd_chk("wdctl reset", WDTTA_ADDR_WDCTL, exp_wd(1, 0, 0, 1));
		rd_chk("clkctl reset", WDTTA_ADDR_CLKCTL, WDTTA_CLKCTL_RST);
		rd_chk("eie reset", WDTTA_ADDR_EIE, WDTTA_EIE_RST);
		// plain registers and an unmapped place, random data
		for (int i = 0; i < 6; i++)
		begin
			v = 8'($urandom);
			a = (i % 2) ? WDTTA_ADDR_EIE : WDTTA_ADDR_CLKCTL;
			cyc(1'b1, 1'b0, a, v);
			rd_chk("plain rw", a, v);
			do
				a = 8'($urandom);
			while (a inside {WDTTA_ADDR_CLKCTL, WDTTA_ADDR_TAKEY, WDTTA_ADDR_WDCTL, WDTTA_ADDR_EIE});
			cyc(1'b1, 1'b0, a, v);
			rd_chk("unmapped", a, 8'h00);
		end
		// longest select, so no warning lands inside the lock checks below
		cyc(1'b1, 1'b0, WDTTA_ADDR_CLKCTL, 8'hc0);
		cyc(1'b1, 1'b0, WDTTA_ADDR_WDCTL, 8'h00);
		rd_chk("no unlock", WDTTA_ADDR_WDCTL, exp_wd(1, 0, 0, 1));
		unlock_wr(11, 8'h40);
		rd_chk("last window edge", WDTTA_ADDR_WDCTL, exp_wd(1, 0, 0, 0));
		unlock_wr(12, 8'h42);
		rd_chk("window closed", WDTTA_ADDR_WDCTL, exp_wd(1, 0, 0, 0));
		// a foreign write between the key bytes disarms the unlock
		cyc(1'b1, 1'b0, WDTTA_ADDR_TAKEY, WDTTA_KEY_FIRST);
		cyc(1'b1, 1'b0, WDTTA_ADDR_EIE, 8'h00);
		cyc(1'b1, 1'b0, WDTTA_ADDR_TAKEY, WDTTA_KEY_SECOND);
		cyc(1'b1, 1'b0, WDTTA_ADDR_WDCTL, 8'h42);
		rd_chk("key broken", WDTTA_ADDR_WDCTL, exp_wd(1, 0, 0, 0));
		// every timeout select; interrupt off on 2, reset function off on 3
		for (int s = 0; s < 4; s++)
		begin
			en = (s != 2);
			rfe = (s != 3);
			unlock_wr(0, {6'h10, rfe, 1'b1});
			cyc(1'b1, 1'b0, WDTTA_ADDR_CLKCTL, {2'(s), 6'h00});
			cyc(1'b1, 1'b0, WDTTA_ADDR_EIE, en ? 8'h10 : 8'h00);
			unlock_wr(0, {6'h10, rfe, 1'b1});
			r0 = resets;
			nw = 0;
			if (en)
				wait_out(0, nw);
			check("wake", 32'(en), 32'(wake_o));
			if (!rfe)
			begin
				idle(520);
				check("reset pulses", r0, resets);
				rd_chk("flags no reset", WDTTA_ADDR_WDCTL, exp_wd(1, 1, 1, 0));
			end
			else
			begin
				wait_out(1, n2);
				total = nw + n2;
				if (s == 0)
					base = total - int'(TSEL[0]) - 512;
				check("base", 32'(base < 0 || base > 2), 32'h0);
				check("reset delay", int'(TSEL[s]) + 512 + base, total);
				if (en)
					check("warn to reset", 512, n2);
				check("irq level", 32'(en), 32'(warn_irq_o));
				idle(3);
				check("one pulse", r0 + 1, resets);
				rd_chk("flags", WDTTA_ADDR_WDCTL, exp_wd(1, 1, 1, 1));
				rst_n_i = 1'b0;
				idle(2);
				rst_n_i = 1'b1;
				rd_chk("after cpu reset", WDTTA_ADDR_WDCTL, exp_wd(1, 0, 1, 1));
			end
		end
		// regular restarts keep the watchdog quiet
		cyc(1'b1, 1'b0, WDTTA_ADDR_CLKCTL, 8'h00);
		cyc(1'b1, 1'b0, WDTTA_ADDR_EIE, 8'h10);
		r0 = resets;
		repeat (8)
		begin
			unlock_wr(0, 8'h43);
			idle(int'(TSEL[0]) - 12);
		end
		check("kept alive irq", 0, 32'(warn_irq_o));
		check("kept alive reset", r0, resets);
		// option bit set: reset function comes up disabled
		nv_reset_disable_i = 1'b1;
		por_n_i = 1'b0;
		idle(2);
		por_n_i = 1'b1;
		rd_chk("option bit", WDTTA_ADDR_WDCTL, exp_wd(1, 0, 0, 0));
		stop_test();
	end
endmodule
